// *** shared/ipva_map.svh ***
// Register offsets, field positions, reset values and vector constants for the pin interrupt block.
`ifndef IPVA_MAP_SVH
`define IPVA_MAP_SVH

`define IPVA_OFF_PIN_CTRL 8'h00
`define IPVA_OFF_SRC_FLAG 8'h04
`define IPVA_OFF_SRC_EN 8'h08
`define IPVA_OFF_EVT_STATUS 8'h0c
`define IPVA_OFF_EVT_MASK 8'h10
`define IPVA_OFF_VEC_STATUS 8'h14
`define IPVA_OFF_SRC_SET 8'h18

`define IPVA_BIT_PULL_DIS 6
`define IPVA_BIT_POLARITY 5
`define IPVA_BIT_PIN_EN 4
`define IPVA_BIT_FLAG 3
`define IPVA_BIT_ACK 2
`define IPVA_BIT_INT_EN 1
`define IPVA_BIT_MODE 0

`define IPVA_PIN_CTRL_RST 8'h00
`define IPVA_VEC_TOP 16'hfffe
`define IPVA_PIN_VECTOR 5'h02
`define IPVA_SCI_RX_VECTOR 5'h11
`define IPVA_NUM_VEC 32

`define IPVA_EVT_PIN 0
`define IPVA_EVT_VECTOR 1

`endif

// *** shared/ipva_pkg.sv ***
// Types shared by the pin interrupt and vector arbiter.
package ipva_pkg;

    typedef struct packed {
        logic pull_dis;
        logic polarity;
        logic pin_en;
        logic int_en;
        logic mode;
    } ipva_pin_ctrl_s;

    typedef struct packed {
        logic valid;
        logic [4:0] number;
        logic [15:0] address;
    } ipva_vector_s;

    typedef struct packed {
        logic pull_en;
        logic pull_down;
    } ipva_pull_s;

    typedef enum logic [2:0] {
        IPVA_IDLE = 3'b001,
        IPVA_STACK = 3'b010,
        IPVA_FETCH = 3'b100
    } ipva_state_e;

endpackage : ipva_pkg

// *** design/ipva_arbiter.sv ***
// External pin interrupt logic and prioritised vector arbiter with Avalon-MM registers.
//
// Overview of operation
// [RULE1] Each event sets its flag; request forwarded only while its local enable is set.
// [RULE2] With global mask clear, CPU finishes, stacks context, sets mask, fetches best vector.
// [RULE3] Thirty-two two-byte vectors at memory top; lower number wins, reset highest.
// [RULE4] A shared vector is raised when any of its flags has its own enable set.
// [RULE5] Pull disable bit 6 switches off the pull device while the pin function is on.
// [RULE6] Polarity bit 5 picks falling/low or rising/high; high makes the pull a pull-down.
// [RULE7] Pin enable bit 4 makes the pin an interrupt request input.
// [RULE8] Pin event flag bit 3 is read-only and set by a qualifying pin event.
// [RULE9] Writing one to acknowledge bit 2 clears the flag; it always reads zero.
// [RULE10] In edge-and-level mode acknowledge cannot clear the flag while the pin is asserted.
// [RULE11] Pin interrupt enable bit 1 requests an interrupt while the flag is set.
// [RULE12] Mode bit 0 selects edge-only, or edges plus matching level.
// [RULE13] The pin is synchronised through two flip-flops before detection.
`timescale 1ns/1ps
`include "ipva_map.svh"

module ipva_arbiter
    import ipva_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // External interrupt pin and its pull device.
    input wire logic irq_pin,
    output ipva_pull_s pin_pull,
    // On-chip event sources, one per vector, as pulses.
    input wire logic [31:0] src_event,
    // CPU core side.
    input wire logic cpu_global_mask,
    input wire logic cpu_insn_done,
    input wire logic cpu_stack_done,
    output logic cpu_int_req,
    output ipva_vector_s cpu_vector,
    output logic cpu_set_mask,
    input wire logic cpu_vector_taken,
    // System interrupt.
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    function automatic logic [4:0] ipva_highest(input logic [31:0] pend);
        logic [4:0] num;
        num = 5'h00;
        for (int i = 31; i >= 0; i--) begin
            if (pend[i]) begin
                num = 5'(i);
            end
        end
        return num;
    endfunction : ipva_highest

    function automatic logic [15:0] ipva_vec_addr(input logic [4:0] num);
        return `IPVA_VEC_TOP - {10'h000, num, 1'b0};
    endfunction : ipva_vec_addr

    function automatic logic ipva_is_mapped(input logic [7:0] addr);
        logic hit;
        hit = 1'b0;
        case (addr)
            `IPVA_OFF_PIN_CTRL, `IPVA_OFF_SRC_FLAG, `IPVA_OFF_SRC_EN, `IPVA_OFF_EVT_STATUS,
            `IPVA_OFF_EVT_MASK, `IPVA_OFF_VEC_STATUS, `IPVA_OFF_SRC_SET: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : ipva_is_mapped

    function automatic logic [31:0] ipva_ctrl_word(input ipva_pin_ctrl_s c, input logic flag);
        // The acknowledge position is write-only and always reads back as zero.
        return {24'h000000, 1'b0, c.pull_dis, c.polarity, c.pin_en, flag, 1'b0,
            c.int_en, c.mode};
    endfunction : ipva_ctrl_word

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and detection.

    logic pin_meta;
    logic pin_sync;
    logic pin_prev;
    ipva_pin_ctrl_s ctrl;
    logic pin_flag;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // The stages reset to the pulled-up idle level, so release shows no false edge.
            pin_meta <= 1'b1;
            pin_sync <= 1'b1;
            pin_prev <= 1'b1;
        end else begin
            pin_meta <= irq_pin; // RULE13
            pin_sync <= pin_meta; // RULE13
            pin_prev <= pin_sync;
        end
    end

    logic pin_asserted;
    logic pin_edge;
    logic pin_event;

    always_comb begin
        pin_asserted = (pin_sync == ctrl.polarity); // RULE6
        // An edge only counts when it ends at the selected level.
        pin_edge = (pin_sync != pin_prev) && pin_asserted; // RULE6
        pin_event = ctrl.pin_en && (pin_edge || (ctrl.mode && pin_asserted)); // RULE7 RULE12
        // The pull follows the pin function; the polarity turns the pull-up into a pull-down.
        pin_pull.pull_en = ctrl.pin_en && !ctrl.pull_dis; // RULE5
        pin_pull.pull_down = ctrl.polarity; // RULE6
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register bus and register state.

    logic [31:0] src_flag;
    logic [31:0] src_en;
    logic [1:0] evt_status;
    logic [1:0] evt_mask;
    logic rd_ack;
    ipva_pin_ctrl_s next_ctrl;
    logic next_pin_flag;
    logic [31:0] next_src_flag;
    logic [31:0] next_src_en;
    logic [1:0] next_evt_status;
    logic [1:0] next_evt_mask;
    logic [31:0] next_readdata;
    logic [1:0] next_response;
    logic next_rd_ack;
    logic wr_ctrl;
    logic ack_hit;
    logic mapped;
    logic [1:0] evt_set;
    logic vec_rise;

    localparam logic [7:0] CTRL_RST = `IPVA_PIN_CTRL_RST;

    always_comb begin
        next_ctrl = ctrl;
        next_pin_flag = pin_flag;
        next_src_flag = src_flag | src_event; // RULE1
        next_src_en = src_en;
        next_evt_mask = evt_mask;
        next_readdata = avs_readdata;
        next_response = avs_response;
        next_rd_ack = 1'b0;
        wr_ctrl = avs_write && avs_byteenable[0] && (avs_address == `IPVA_OFF_PIN_CTRL);
        ack_hit = wr_ctrl && avs_writedata[`IPVA_BIT_ACK]; // RULE9
        mapped = ipva_is_mapped(avs_address);
        if (ack_hit && !(ctrl.mode && ctrl.pin_en && pin_asserted)) begin
            next_pin_flag = 1'b0; // RULE9 RULE10
        end
        // A pin event wins over an acknowledge in the same cycle, so no event is lost.
        if (pin_event) begin
            next_pin_flag = 1'b1; // RULE8
        end
        if (wr_ctrl) begin
            next_ctrl.pull_dis = avs_writedata[`IPVA_BIT_PULL_DIS];
            next_ctrl.polarity = avs_writedata[`IPVA_BIT_POLARITY];
            next_ctrl.pin_en = avs_writedata[`IPVA_BIT_PIN_EN];
            next_ctrl.int_en = avs_writedata[`IPVA_BIT_INT_EN];
            next_ctrl.mode = avs_writedata[`IPVA_BIT_MODE];
        end
        // Wide registers change only on a full-word write, so a partial write cannot tear them.
        if (avs_write && (avs_byteenable == 4'hf)) begin
            case (avs_address)
                `IPVA_OFF_SRC_FLAG: next_src_flag = (src_flag & ~avs_writedata) | src_event;
                `IPVA_OFF_SRC_EN: next_src_en = avs_writedata;
                `IPVA_OFF_EVT_MASK: next_evt_mask = avs_writedata[1:0];
                `IPVA_OFF_SRC_SET: next_src_flag = src_flag | src_event | avs_writedata;
                default: next_src_en = src_en;
            endcase
        end
        evt_set = 2'b00;
        evt_set[`IPVA_EVT_PIN] = pin_event && !pin_flag;
        evt_set[`IPVA_EVT_VECTOR] = vec_rise;
        // Hardware setting wins over a software clear in the same cycle.
        next_evt_status = evt_status | evt_set;
        if (avs_write && (avs_address == `IPVA_OFF_EVT_STATUS)) begin
            next_evt_status = (evt_status & ~avs_writedata[1:0]) | evt_set;
        end
        if (avs_read && !rd_ack) begin
            next_rd_ack = 1'b1;
            next_response = mapped ? 2'b00 : 2'b10;
            case (avs_address)
                `IPVA_OFF_PIN_CTRL: next_readdata = ipva_ctrl_word(ctrl, pin_flag); // RULE9
                `IPVA_OFF_SRC_FLAG: next_readdata = src_flag;
                `IPVA_OFF_SRC_EN: next_readdata = src_en;
                `IPVA_OFF_EVT_STATUS: next_readdata = {30'h00000000, evt_status};
                `IPVA_OFF_EVT_MASK: next_readdata = {30'h00000000, evt_mask};
                `IPVA_OFF_VEC_STATUS: next_readdata = {cpu_vector.address, 8'h00,
                    2'b00, cpu_vector.valid, cpu_vector.number};
                default: next_readdata = 32'h00000000;
            endcase
        end
        if (avs_write) begin
            next_response = mapped ? 2'b00 : 2'b10;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl.pull_dis <= CTRL_RST[`IPVA_BIT_PULL_DIS];
            ctrl.polarity <= CTRL_RST[`IPVA_BIT_POLARITY];
            ctrl.pin_en <= CTRL_RST[`IPVA_BIT_PIN_EN];
            ctrl.int_en <= CTRL_RST[`IPVA_BIT_INT_EN];
            ctrl.mode <= CTRL_RST[`IPVA_BIT_MODE];
            pin_flag <= 1'b0;
            src_flag <= 32'h00000000;
            src_en <= 32'h00000000;
            evt_status <= 2'b00;
            evt_mask <= 2'b00;
            avs_readdata <= 32'h00000000;
            avs_response <= 2'b00;
            rd_ack <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            pin_flag <= next_pin_flag;
            src_flag <= next_src_flag;
            src_en <= next_src_en;
            evt_status <= next_evt_status;
            evt_mask <= next_evt_mask;
            avs_readdata <= next_readdata;
            avs_response <= next_response;
            rd_ack <= next_rd_ack;
        end
    end

    // Reads take one wait state because read data come from a register.
    assign avs_waitrequest = avs_read && !rd_ack;
    assign irq_out = |(evt_status & evt_mask);

    ////////////////////////////////////////////////////////////////////////////
    // Priority arbitration and CPU vectoring sequence.

    logic [31:0] pend;
    logic [4:0] best;
    logic any_pend;
    ipva_state_e state;
    ipva_state_e next_state;
    ipva_vector_s next_vector;
    logic next_set_mask;

    always_comb begin
        pend = src_flag & src_en; // RULE1 RULE4
        // The pin vector is fed by the pin flag gated by its interrupt enable; its source flag bit is unused.
        pend[`IPVA_PIN_VECTOR] = pin_flag && ctrl.int_en; // RULE11
        any_pend = |pend;
        best = ipva_highest(pend); // RULE3
        cpu_int_req = any_pend && !cpu_global_mask; // RULE2
        next_state = state;
        next_vector = cpu_vector;
        next_set_mask = 1'b0;
        vec_rise = 1'b0;
        case (state)
            IPVA_IDLE: begin
                next_vector.valid = 1'b0;
                if (cpu_int_req && cpu_insn_done) begin
                    next_state = IPVA_STACK; // RULE2
                end
            end
            // The vector is chosen when stacking ends, so a later, higher source still wins.
            IPVA_STACK: begin
                if (cpu_stack_done) begin
                    next_set_mask = 1'b1; // RULE2
                    next_vector.valid = any_pend;
                    next_vector.number = best; // RULE3
                    next_vector.address = ipva_vec_addr(best); // RULE3
                    vec_rise = any_pend;
                    next_state = any_pend ? IPVA_FETCH : IPVA_IDLE;
                end
            end
            // The vector stands until the core has fetched it.
            IPVA_FETCH: begin
                if (cpu_vector_taken) begin
                    next_vector.valid = 1'b0;
                    next_state = IPVA_IDLE;
                end
            end
            default: next_state = IPVA_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= IPVA_IDLE;
            cpu_vector <= '0;
            cpu_set_mask <= 1'b0;
        end else begin
            state <= next_state;
            cpu_vector <= next_vector;
            cpu_set_mask <= next_set_mask;
        end
    end

endmodule : ipva_arbiter

// *** sim/ipva_arbiter_monitor.sv ***
// Port assertions for the pin interrupt and vector arbiter.
`timescale 1ns/1ps
module ipva_monitor
    import ipva_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // CPU side.
    input wire logic cpu_global_mask,
    input wire logic cpu_stack_done,
    input wire logic cpu_int_req,
    input wire ipva_vector_s cpu_vector,
    input wire logic cpu_set_mask,
    input wire logic cpu_vector_taken
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    rd_stall_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("no stall");
    rd_end_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("slow read");
    wr_free_a: assert property (avs_write |-> !avs_waitrequest) else $error("write stall");
    bad_addr_a: assert property (avs_read && !avs_waitrequest && avs_address > 8'h18
        |-> avs_response == 2'h2 && avs_readdata == 32'h0) else $error("unmapped read");
    vec_addr_a: assert property (cpu_vector.valid |-> cpu_vector.address ==
        16'hfffe - {10'h0, cpu_vector.number, 1'b0}) else $error("vector address");
    vec_hold_a: assert property (cpu_vector.valid && !cpu_vector_taken
        |=> cpu_vector.valid && $stable(cpu_vector.number)) else $error("vector dropped");
    mask_set_a: assert property ($rose(cpu_vector.valid) |-> cpu_set_mask
        && $past(cpu_stack_done)) else $error("mask not set");
    mask_once_a: assert property (cpu_set_mask |=> !cpu_set_mask) else $error("long mask");
    gmask_a: assert property (cpu_global_mask |-> !cpu_int_req) else $error("masked req");
    stack_c: cover property (cpu_stack_done);
    take_c: cover property (cpu_vector_taken);
    read_c: cover property (avs_read && !avs_waitrequest);
endmodule : ipva_monitor
////////////////////////////////////////////////////////////
bind ipva_arbiter ipva_monitor u_mon (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_readdata, .avs_waitrequest, .avs_response, .cpu_global_mask, .cpu_stack_done,
    .cpu_int_req, .cpu_vector, .cpu_set_mask, .cpu_vector_taken);

// *** sim/ipva_cpu_model.sv ***
// Behavioural CPU core that stacks context and fetches vectors.
`timescale 1ns/1ps
module ipva_cpu_model
    import ipva_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Arbiter side.
    input wire logic cpu_int_req,
    input wire ipva_vector_s cpu_vector,
    input wire logic cpu_set_mask,
    output logic cpu_global_mask,
    output logic cpu_insn_done,
    output logic cpu_stack_done,
    output logic cpu_vector_taken,
    // Bench side.
    input wire logic unmask,
    input wire logic [3:0] stack_wait
);
    logic busy;
    logic [3:0] cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {cpu_global_mask, cpu_insn_done, cpu_stack_done, cpu_vector_taken} <= 4'h0;
            busy <= 1'b0;
            cnt <= 4'h0;
        end else begin
            // Stacking takes stack_wait plus one cycles after busy rises, so the bench can make it prompt or slow.
            cpu_insn_done <= cpu_int_req && !busy && !cpu_insn_done;
            busy <= (busy || cpu_insn_done) && !cpu_vector_taken;
            cnt <= busy ? cnt + 4'h1 : 4'h0;
            cpu_stack_done <= busy && cnt == stack_wait;
            cpu_vector_taken <= cpu_vector.valid && !cpu_vector_taken;
            cpu_global_mask <= cpu_set_mask || (cpu_global_mask && !unmask);
        end
    end
endmodule : ipva_cpu_model

// *** sim/tb_top.sv ***
// Self-checking bench for the pin interrupt and vector arbiter.
`timescale 1ns/1ps
`include "ipva_map.svh"
module tb_top
    import ipva_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    logic irq_pin = 1'b1;
    ipva_pull_s pin_pull;
    logic [31:0] src_event = 32'h0;
    logic cpu_global_mask, cpu_insn_done, cpu_stack_done, cpu_int_req;
    ipva_vector_s cpu_vector;
    logic cpu_set_mask, cpu_vector_taken, irq_out;
    logic unmask = 1'b0;
    logic [3:0] stack_wait = 4'h0;
    logic [31:0] rd;
    int err_count = 0;
    int num_checks = 0;
    always #5 clk = ~clk;
    ipva_arbiter u_dut (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .irq_pin, .pin_pull,
        .src_event, .cpu_global_mask, .cpu_insn_done, .cpu_stack_done, .cpu_int_req,
        .cpu_vector, .cpu_set_mask, .cpu_vector_taken, .irq_out);
    ipva_cpu_model u_cpu (.clk, .rst, .cpu_int_req, .cpu_vector, .cpu_set_mask,
        .cpu_global_mask, .cpu_insn_done, .cpu_stack_done, .cpu_vector_taken, .unmask,
        .stack_wait);
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rchk
    task automatic take(input logic [4:0] num, input logic [15:0] addr);
        for (int i = 0; i < 40 && cpu_vector_taken !== 1'b1; i++) @(posedge clk);
        chk("taken", 32'h1, {31'h0, cpu_vector_taken});
        chk("vector", {27'h0, num}, {27'h0, cpu_vector.number});
        chk("address", {16'h0, addr}, {16'h0, cpu_vector.address});
    endtask : take
    task automatic unm;
        unmask <= 1'b1;
        @(posedge clk);
        unmask <= 1'b0;
    endtask : unm
    task automatic t_regs;
        rchk("ctrl", `IPVA_OFF_PIN_CTRL, 32'h0);
        rchk("enables", `IPVA_OFF_SRC_EN, 32'h0);
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h5f);
        rchk("ctrl", `IPVA_OFF_PIN_CTRL, 32'h53);
        chk("pull", 32'h0, {30'h0, pin_pull});
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h30);
        rchk("ctrl", `IPVA_OFF_PIN_CTRL, 32'h30);
        chk("pull", 32'h3, {30'h0, pin_pull});
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h10);
        rchk("ctrl", `IPVA_OFF_PIN_CTRL, 32'h10);
        chk("pull", 32'h2, {30'h0, pin_pull});
        rchk("unmapped", 8'h40, 32'h0);
        chk("response", 32'h2, {30'h0, avs_response});
    endtask : t_regs
    task automatic t_edge;
        bus(1'b1, `IPVA_OFF_EVT_MASK, 32'h1);
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h02);
        irq_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rchk("pin off", `IPVA_OFF_PIN_CTRL, 32'h02);
        irq_pin <= 1'b1;
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h12);
        irq_pin <= 1'b0;
        take(5'h02, 16'hfffa);
        chk("irq_out", 32'h1, {31'h0, irq_out});
        bus(1'b1, `IPVA_OFF_EVT_STATUS, 32'h1);
        rchk("flag", `IPVA_OFF_PIN_CTRL, 32'h1a);
        chk("irq_out", 32'h0, {31'h0, irq_out});
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h16);
        rchk("ack", `IPVA_OFF_PIN_CTRL, 32'h12);
        unm();
    endtask : t_edge
    task automatic t_level;
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h11);
        rchk("low level", `IPVA_OFF_PIN_CTRL, 32'h19);
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h15);
        rchk("ack held", `IPVA_OFF_PIN_CTRL, 32'h19);
        irq_pin <= 1'b1;
        repeat (4) @(posedge clk);
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h15);
        rchk("ack", `IPVA_OFF_PIN_CTRL, 32'h11);
        bus(1'b1, `IPVA_OFF_PIN_CTRL, 32'h31);
        rchk("high level", `IPVA_OFF_PIN_CTRL, 32'h39);
    endtask : t_level
    task automatic t_vec;
        stack_wait <= 4'h3;
        bus(1'b1, `IPVA_OFF_EVT_STATUS, 32'h3);
        bus(1'b1, `IPVA_OFF_SRC_EN, 32'h0202_0000);
        src_event <= 32'h4202_0000;
        @(posedge clk);
        src_event <= 32'h0;
        take(5'h11, 16'hffdc);
        rchk("vec event", `IPVA_OFF_EVT_STATUS, 32'h2);
        rchk("flags", `IPVA_OFF_SRC_FLAG, 32'h4202_0000);
        bus(1'b1, `IPVA_OFF_SRC_FLAG, 32'h0002_0000);
        unm();
        take(5'h19, 16'hffcc);
        bus(1'b1, `IPVA_OFF_SRC_FLAG, 32'h0200_0000);
        bus(1'b1, `IPVA_OFF_SRC_SET, 32'h0000_0008);
        rchk("set", `IPVA_OFF_SRC_FLAG, 32'h4000_0008);
        unm();
        repeat (2) @(posedge clk);
        chk("int_req", 32'h0, {31'h0, cpu_int_req});
    endtask : t_vec
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_edge();
        t_level();
        t_vec();
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("mismatch watchdog expected %s seen %s", "finish", "timeout");
        give_verdict();
    end
endmodule : tb_top
